/* File: erv_defs.vh */
// constants for the external request pin and vector logic
`ifndef ERV_DEFS_VH
`define ERV_DEFS_VH

// register byte offsets
`define ERV_OFF_STATUS_CONTROL 12'h000
`define ERV_OFF_LOCAL_ENABLE 12'h004
`define ERV_OFF_PENDING 12'h008
`define ERV_OFF_IRQ_STATUS 12'h00c
`define ERV_OFF_IRQ_MASK 12'h010
`define ERV_OFF_VECTOR_INFO 12'h014

// ext_request_status_control field positions
`define ERV_BIT_DETECT_MODE 0
`define ERV_BIT_INT_ENABLE 1
`define ERV_BIT_ACKNOWLEDGE 2
`define ERV_BIT_FLAG 3
`define ERV_BIT_PIN_ENABLE 4
`define ERV_BIT_PULL_DISABLE 6

// irq status / mask field positions
`define ERV_EVT_PIN 0
`define ERV_EVT_ENTRY 1
`define ERV_EVT_W 2

// vector_info field positions
`define ERV_VI_NUM_LSB 0
`define ERV_VI_ADDR_LSB 8
`define ERV_VI_LEVEL 24

// reset values
`define ERV_RST_LOCAL_ENABLE 32'h0000_0000
`define ERV_RST_IRQ_MASK 2'h0

// vector map
`define ERV_VEC_TOP 16'hfffe
`define ERV_VEC_PIN 5'h02
`define ERV_VEC_W 5

// stack push selector codes
`define ERV_PUSH_NONE 3'h0
`define ERV_PUSH_PC_LOW 3'h1
`define ERV_PUSH_PC_HIGH 3'h2
`define ERV_PUSH_INDEX_LOW 3'h3
`define ERV_PUSH_ACC 3'h4
`define ERV_PUSH_CCR 3'h5

`endif

/* File: erv_ctrl.v */
// external request pin detector, vector priority and cpu entry sequencer
`timescale 1ns/1ps
`include "erv_defs.vh"

// Behaviour
// - pin raises events only when enabled
// - mode picks edge-only or edge-and-level detection
// - events always set flag; cpu request needs enable
// - pullup on while pin enabled, pull disable turns off
// - synced pin level offered to branch instructions
// - edge-and-level mode sets flag on assertion
// - in edge-and-level mode flag stays set while pin held low
// - vector two bytes, high byte first
// - each source flag forwarded only when enabled
// - unmasked entry: finish, stack five, mask, fetch
// - lower vector number wins, fixed priority
// - vectors descend from top address pair
// - acknowledge one clears flag, reads zero
// - events are falling edges, optionally low levels
// - asynchronous wake path while clocks stopped
module erv_ctrl #(
  parameter NUM_VEC = 32
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output reg pslverr,
  input wire ext_request_pin_n,
  output wire ext_request_pull_en,
  output wire ext_request_wake,
  output reg ext_request_pin_level,
  input wire [NUM_VEC-1:0] src_flag,
  input wire cpu_global_mask,
  input wire cpu_insn_done,
  output reg entry_busy,
  output reg [2:0] stack_push_sel,
  output reg stack_push,
  output reg mask_set,
  output reg vec_fetch,
  output reg [15:0] vec_fetch_addr,
  output reg [4:0] vec_num,
  output wire irq
);

  localparam [8:0] ST_IDLE = 9'h001;
  localparam [8:0] ST_PC_LOW = 9'h002;
  localparam [8:0] ST_PC_HIGH = 9'h004;
  localparam [8:0] ST_INDEX = 9'h008;
  localparam [8:0] ST_ACC = 9'h010;
  localparam [8:0] ST_CCR = 9'h020;
  localparam [8:0] ST_MASK = 9'h040;
  localparam [8:0] ST_FETCH_HI = 9'h080;
  localparam [8:0] ST_FETCH_LO = 9'h100;

  reg detect_mode_r;
  reg int_enable_r;
  reg pin_enable_r;
  reg pull_disable_r;
  reg flag_r;
  reg flag_nxt;
  reg [NUM_VEC-1:0] local_en_r;
  reg [`ERV_EVT_W-1:0] evt_status_r;
  reg [`ERV_EVT_W-1:0] evt_status_nxt;
  reg [`ERV_EVT_W-1:0] evt_mask_r;
  reg sync1_r;
  reg sync2_r;
  reg prev_r;
  reg [8:0] state_r;
  reg [8:0] state_nxt;
  reg [4:0] sel_num_r;
  reg [4:0] win_num;
  reg win_any;
  reg [NUM_VEC-1:0] pending;
  reg [31:0] rd_val;
  reg rd_err;
  integer i;

  wire setup_ph = psel & ~penable;
  wire wr_en = psel & penable & pwrite;
  wire wr_ctrl = wr_en & (paddr == `ERV_OFF_STATUS_CONTROL);
  // acknowledge only acts on a one; a zero is ignored
  wire ack = wr_ctrl & pwdata[`ERV_BIT_ACKNOWLEDGE];
  wire pin_low = ~sync2_r;
  wire fall = prev_r & ~sync2_r;
  wire pin_event = pin_enable_r & (fall | (detect_mode_r & pin_low));
  wire entry_done = state_r[8];
  wire [15:0] win_addr = `ERV_VEC_TOP - {10'h000, win_num, 1'b0};

  // zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;

  assign ext_request_pull_en = pin_enable_r & ~pull_disable_r;

  // unclocked wake path
  // reads the raw pin on purpose: with the clock stopped no flop can help
  assign ext_request_wake = pin_enable_r & ~ext_request_pin_n;

  // level of the sticky status, so it stays up until software clears it
  assign irq = |(evt_status_r & evt_mask_r);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_r <= 1'b1;
      sync2_r <= 1'b1;
      prev_r <= 1'b1;
    end else begin
      sync1_r <= ext_request_pin_n;
      sync2_r <= sync1_r;
      // prev follows the pin even while disabled, so enabling the pin
      // while it is already low does not fake a falling edge
      prev_r <= sync2_r;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_request_pin_level <= 1'b1;
    end else begin
      ext_request_pin_level <= pin_enable_r ? sync2_r : 1'b1;
    end
  end

  always @* begin
    flag_nxt = flag_r;
    if (ack) begin
      flag_nxt = 1'b0;
    end
    if (pin_event) begin
      flag_nxt = 1'b1;
    end
  end

  always @* begin
    evt_status_nxt = evt_status_r;
    if (wr_en && paddr == `ERV_OFF_IRQ_STATUS) begin
      evt_status_nxt = evt_status_r & ~pwdata[`ERV_EVT_W-1:0];
    end
    // a new event outranks a same-cycle clear
    if (pin_event) begin
      evt_status_nxt[`ERV_EVT_PIN] = 1'b1;
    end
    if (entry_done) begin
      evt_status_nxt[`ERV_EVT_ENTRY] = 1'b1;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      detect_mode_r <= 1'b0;
      int_enable_r <= 1'b0;
      pin_enable_r <= 1'b0;
      pull_disable_r <= 1'b0;
      flag_r <= 1'b0;
      local_en_r <= `ERV_RST_LOCAL_ENABLE;
      evt_status_r <= {`ERV_EVT_W{1'b0}};
      evt_mask_r <= `ERV_RST_IRQ_MASK;
    end else begin
      flag_r <= flag_nxt;
      evt_status_r <= evt_status_nxt;
      if (wr_ctrl) begin
        detect_mode_r <= pwdata[`ERV_BIT_DETECT_MODE];
        int_enable_r <= pwdata[`ERV_BIT_INT_ENABLE];
        pin_enable_r <= pwdata[`ERV_BIT_PIN_ENABLE];
        pull_disable_r <= pwdata[`ERV_BIT_PULL_DISABLE];
      end
      if (wr_en && paddr == `ERV_OFF_LOCAL_ENABLE) begin
        local_en_r <= pwdata[NUM_VEC-1:0];
      end
      if (wr_en && paddr == `ERV_OFF_IRQ_MASK) begin
        evt_mask_r <= pwdata[`ERV_EVT_W-1:0];
      end
    end
  end

  always @* begin
    pending = src_flag & local_en_r;
    pending[`ERV_VEC_PIN] = flag_r & int_enable_r;
    win_any = 1'b0;
    win_num = 5'h00;
    // lowest number wins
    // counting down lets the lowest pending index be written last
    for (i = NUM_VEC - 1; i >= 0; i = i - 1) begin
      if (pending[i]) begin
        win_any = 1'b1;
        win_num = i[4:0];
      end
    end
  end

  always @* begin
    rd_val = 32'h0000_0000;
    rd_err = 1'b0;
    case (paddr)
      `ERV_OFF_STATUS_CONTROL: begin
        rd_val[`ERV_BIT_DETECT_MODE] = detect_mode_r;
        rd_val[`ERV_BIT_INT_ENABLE] = int_enable_r;
        rd_val[`ERV_BIT_FLAG] = flag_r;
        rd_val[`ERV_BIT_PIN_ENABLE] = pin_enable_r;
        rd_val[`ERV_BIT_PULL_DISABLE] = pull_disable_r;
      end
      `ERV_OFF_LOCAL_ENABLE: begin
        rd_val[NUM_VEC-1:0] = local_en_r;
      end
      `ERV_OFF_PENDING: begin
        rd_val[NUM_VEC-1:0] = pending;
      end
      `ERV_OFF_IRQ_STATUS: begin
        rd_val[`ERV_EVT_W-1:0] = evt_status_r;
      end
      `ERV_OFF_IRQ_MASK: begin
        rd_val[`ERV_EVT_W-1:0] = evt_mask_r;
      end
      `ERV_OFF_VECTOR_INFO: begin
        rd_val[`ERV_VI_NUM_LSB +: 5] = vec_num;
        rd_val[`ERV_VI_ADDR_LSB +: 16] = `ERV_VEC_TOP - {10'h000, vec_num, 1'b0};
        rd_val[`ERV_VI_LEVEL] = ext_request_pin_level;
      end
      // unmapped offsets read zero and answer with an error
      default: begin
        rd_err = 1'b1;
      end
    endcase
  end

  // read data is captured in the setup cycle so it comes from a flop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (setup_ph) begin
      prdata <= pwrite ? 32'h0000_0000 : rd_val;
      pslverr <= rd_err;
    end
  end

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (win_any && !cpu_global_mask && cpu_insn_done) begin
          state_nxt = ST_PC_LOW;
        end
      end
      ST_PC_LOW: begin
        state_nxt = ST_PC_HIGH;
      end
      ST_PC_HIGH: begin
        state_nxt = ST_INDEX;
      end
      ST_INDEX: begin
        state_nxt = ST_ACC;
      end
      ST_ACC: begin
        state_nxt = ST_CCR;
      end
      ST_CCR: begin
        state_nxt = ST_MASK;
      end
      ST_MASK: begin
        state_nxt = ST_FETCH_HI;
      end
      ST_FETCH_HI: begin
        state_nxt = ST_FETCH_LO;
      end
      ST_FETCH_LO: begin
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_IDLE;
      sel_num_r <= 5'h00;
      entry_busy <= 1'b0;
      stack_push_sel <= `ERV_PUSH_NONE;
      stack_push <= 1'b0;
      mask_set <= 1'b0;
      vec_fetch <= 1'b0;
      vec_fetch_addr <= `ERV_VEC_TOP;
      vec_num <= 5'h00;
    end else begin
      state_r <= state_nxt;
      // strobes are decoded from state_nxt so they line up with state_r
      entry_busy <= ~state_nxt[0];
      stack_push <= state_nxt[1] | state_nxt[2] | state_nxt[3] | state_nxt[4] | state_nxt[5];
      mask_set <= state_nxt[6];
      vec_fetch <= state_nxt[7] | state_nxt[8];
      // the winner is chosen at mask time; a request that vanished while
      // stacking keeps the one chosen at entry so the fetch is never empty
      if (state_r[6] && win_any) begin
        sel_num_r <= win_num;
      end else if (state_r[0]) begin
        sel_num_r <= win_num;
      end
      // selector names the byte that the cpu stacks in this cycle
      case (state_nxt)
        ST_PC_LOW: stack_push_sel <= `ERV_PUSH_PC_LOW;
        ST_PC_HIGH: stack_push_sel <= `ERV_PUSH_PC_HIGH;
        ST_INDEX: stack_push_sel <= `ERV_PUSH_INDEX_LOW;
        ST_ACC: stack_push_sel <= `ERV_PUSH_ACC;
        ST_CCR: stack_push_sel <= `ERV_PUSH_CCR;
        default: stack_push_sel <= `ERV_PUSH_NONE;
      endcase
      if (state_nxt[7]) begin
        vec_fetch_addr <= (state_r[6] && win_any) ? win_addr :
                          `ERV_VEC_TOP - {10'h000, sel_num_r, 1'b0};
        vec_num <= (state_r[6] && win_any) ? win_num : sel_num_r;
      end else if (state_nxt[8]) begin
        vec_fetch_addr <= vec_fetch_addr + 16'h0001;
      end
    end
  end

endmodule

/* File: erv_cpu_model.sv */
// cpu core stand-in: instruction boundaries and the global mask bit
`timescale 1ns/1ps
module erv_cpu_model #(
  parameter GAP = 3
) (
  input wire pclk,
  input wire presetn,
  input wire mask_set,
  input wire unmask,
  output logic cpu_global_mask,
  output logic cpu_insn_done
);
  logic [3:0] cnt_r;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r <= 4'h0;
      cpu_global_mask <= 1'b1;
      cpu_insn_done <= 1'b0;
    end else begin
      cnt_r <= (cnt_r == GAP) ? 4'h0 : cnt_r + 4'h1;
      cpu_insn_done <= (cnt_r == GAP);
      if (mask_set) begin
        cpu_global_mask <= 1'b1;
      end else if (unmask) begin
        cpu_global_mask <= 1'b0;
      end
    end
  end
endmodule

/* File: erv_ctrl_chk.sv */
// assertions on the pin detector and entry sequencer ports
`timescale 1ns/1ps
module erv_ctrl_chk (
  input wire pclk,
  input wire presetn,
  input wire ext_request_pin_n,
  input wire ext_request_wake,
  input wire ext_request_pin_level,
  input wire cpu_global_mask,
  input wire cpu_insn_done,
  input wire entry_busy,
  input wire [2:0] stack_push_sel,
  input wire stack_push,
  input wire mask_set,
  input wire vec_fetch,
  input wire [15:0] vec_fetch_addr,
  input wire [4:0] vec_num
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_stack;
    stack_push && stack_push_sel == 3'h1 ##1 stack_push && stack_push_sel == 3'h2
    ##1 stack_push && stack_push_sel == 3'h3 ##1 stack_push && stack_push_sel == 3'h4
    ##1 stack_push && stack_push_sel == 3'h5;
  endsequence
  sequence s_fetch;
    mask_set ##1 vec_fetch [*2] ##1 !vec_fetch;
  endsequence
  AST_ENTRY: assert property ($rose(stack_push) |-> s_stack ##1 s_fetch)
    else $error("entry steps out of order");
  AST_TAKE: assert property ($rose(stack_push) |->
    $past(cpu_insn_done) && !$past(cpu_global_mask)) else $error("entry not allowed");
  AST_ADDR: assert property ($rose(vec_fetch) |->
    vec_fetch_addr == 16'hfffe - {10'h0, vec_num, 1'b0}) else $error("vector address");
  AST_LOBYTE: assert property ($rose(vec_fetch) |=>
    vec_fetch_addr == $past(vec_fetch_addr) + 16'h1) else $error("low byte address");
  AST_VNUM: assert property ($rose(vec_fetch) |=> $stable(vec_num))
    else $error("vector number moved");
  AST_BUSY: assert property (stack_push |-> entry_busy)
    else $error("push outside entry");
  AST_WAKE: assert property (ext_request_wake |-> !ext_request_pin_n)
    else $error("wake with pin high");
  AST_LEVEL: assert property (ext_request_wake [*4] |-> !ext_request_pin_level)
    else $error("pin level not low");
  AST_SYNC: assert property ($fell(ext_request_pin_level) |->
    !$past(ext_request_pin_n, 3)) else $error("pin level ahead of synchroniser");
endmodule
bind erv_ctrl erv_ctrl_chk u_chk (.pclk, .presetn, .ext_request_pin_n, .ext_request_wake,
  .ext_request_pin_level, .cpu_global_mask, .cpu_insn_done, .entry_busy, .stack_push_sel,
  .stack_push, .mask_set, .vec_fetch, .vec_fetch_addr, .vec_num);

/* File: test_ext_request_pin_and_vector_logic.sv */
// self-checking bench for the request pin detector and vector sequencer
`timescale 1ns/1ps
module test_ext_request_pin_and_vector_logic;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic ext_request_pin_n = 1'b1, unmask = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, src_flag = 32'h0, rd;
  logic err = 1'b0;
  wire [31:0] prdata;
  wire pready, pslverr, ext_request_pull_en, ext_request_wake, ext_request_pin_level;
  wire cpu_global_mask, cpu_insn_done, entry_busy, stack_push, mask_set, vec_fetch, irq;
  wire [2:0] stack_push_sel;
  wire [15:0] vec_fetch_addr;
  wire [4:0] vec_num;
  int n_mismatch = 0, samples_checked = 0, i;
  always #12.5 pclk = ~pclk;
  erv_ctrl DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .ext_request_pin_n, .ext_request_pull_en, .ext_request_wake,
    .ext_request_pin_level, .src_flag, .cpu_global_mask, .cpu_insn_done, .entry_busy,
    .stack_push_sel, .stack_push, .mask_set, .vec_fetch, .vec_fetch_addr, .vec_num, .irq);
  erv_cpu_model #(.GAP(3)) u_cpu (.pclk, .presetn, .mask_set, .unmask, .cpu_global_mask,
    .cpu_insn_done);
  task wrap_up;
    if (n_mismatch == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    rd = prdata;
    err = pslverr;
    if (pready !== 1'b1) begin
      n_mismatch++;
      wrap_up;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task rd_chk(input [11:0] a, input [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task port_chk(input [31:0] got, input [31:0] exp);
    @(negedge pclk);
    chk(got, exp);
    @(posedge pclk);
  endtask
  // unmask, then wait for the vector fetch under a bound
  task fetch_chk(input [4:0] n, input [15:0] a);
    unmask <= 1'b1;
    @(posedge pclk);
    unmask <= 1'b0;
    for (i = 0; i < 80 && vec_fetch !== 1'b1; i++) @(negedge pclk);
    if (vec_fetch !== 1'b1) begin
      n_mismatch++;
      wrap_up;
    end
    chk(vec_num, n);
    chk(vec_fetch_addr, a);
    @(posedge pclk);
  endtask
  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd_chk(12'h000, 32'h0);
    apb(1'b1, 12'h000, 32'h10);
    port_chk(ext_request_pull_en, 32'h1);
    apb(1'b1, 12'h000, 32'h50);
    port_chk(ext_request_pull_en, 32'h0);
    apb(1'b1, 12'h000, 32'h10);
    ext_request_pin_n <= 1'b0;
    repeat (4) @(posedge pclk);
    rd_chk(12'h000, 32'h18);
    rd_chk(12'h008, 32'h0);
    port_chk(ext_request_pin_level, 32'h0);
    port_chk(ext_request_wake, 32'h1);
    apb(1'b1, 12'h000, 32'h14);
    rd_chk(12'h000, 32'h10);
    ext_request_pin_n <= 1'b1;
    repeat (4) @(posedge pclk);
    // the acknowledge lands on the edge that sees the fresh fall
    ext_request_pin_n <= 1'b0;
    @(posedge pclk);
    apb(1'b1, 12'h000, 32'h14);
    rd_chk(12'h000, 32'h18);
    apb(1'b1, 12'h000, 32'h14);
    rd_chk(12'h000, 32'h10);
    ext_request_pin_n <= 1'b1;
    apb(1'b1, 12'h000, 32'h11);
    ext_request_pin_n <= 1'b0;
    repeat (4) @(posedge pclk);
    apb(1'b1, 12'h000, 32'h15);
    rd_chk(12'h000, 32'h19);
    ext_request_pin_n <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1'b1, 12'h000, 32'h15);
    rd_chk(12'h000, 32'h11);
    apb(1'b1, 12'h000, 32'h01);
    ext_request_pin_n <= 1'b0;
    repeat (4) @(posedge pclk);
    rd_chk(12'h000, 32'h01);
    port_chk(ext_request_wake, 32'h0);
    port_chk(ext_request_pin_level, 32'h1);
    ext_request_pin_n <= 1'b1;
    apb(1'b1, 12'h004, 32'hffff_ffff);
    src_flag <= 32'h0080_0024;
    rd_chk(12'h008, 32'h0080_0020);
    fetch_chk(5'h05, 16'hfff4);
    rd_chk(12'h014, 32'h01ff_f405);
    apb(1'b1, 12'h000, 32'h12);
    ext_request_pin_n <= 1'b0;
    repeat (4) @(posedge pclk);
    fetch_chk(5'h02, 16'hfffa);
    apb(1'b1, 12'h010, 32'h3);
    port_chk(irq, 32'h1);
    apb(1'b1, 12'h00c, 32'h3);
    port_chk(irq, 32'h0);
    rd_chk(12'h100, 32'h0);
    chk(err, 32'h1);
    wrap_up;
  end
endmodule
